/* hw/i2cm_master.sv */
// Two-wire bus master: registers, sequencer, bus monitor
`timescale 1ns/10ps
`include "i2cm_consts.svh"
module i2cm_master (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire i2cm_pkg::i2cm_word_t ADDR,
   input wire i2cm_pkg::i2cm_word_t WDATA,
   input wire logic WR,
   input wire logic RD,
   output i2cm_pkg::i2cm_word_t RDATA,
   input wire logic SCL_IN,
   output logic SCL_OUT,
   output logic SCL_OE,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input wire logic SLEEP,
   input wire logic CPU_IDLE,
   output logic MASTER_EVENT
);
   import i2cm_pkg::*;

   i2cm_brg_if brg ();
   i2cm_state_e state_ff, nxt_state;
   i2cm_kind_e kind_ff, nxt_kind;
   logic [1:0] step_ff, nxt_step;
   logic [3:0] bitn_ff, nxt_bitn;
   logic scl_oe_ff, nxt_scl_oe, sda_oe_ff, nxt_sda_oe;
   logic [7:0] rx_sh_ff, nxt_rx_sh, rcv_ff, trn_ff, mon_sh_ff;
   logic ack_received_ff, nxt_ack_received;
   i2cm_word_t con_ff, brg_ff, add_ff, rdata_ff, req_clr;
   logic tx_in_progress_ff, tbf_ff, rbf_ff, bcl_ff, gcstat_ff, p_ff, s_ff;
   logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
   logic event_ff, coll_wait_ff, low_ff, mon_arm_ff, gc_pend_ff;
   logic [3:0] mon_cnt_ff;
   logic coll, cond_done, tx_done, rx_done, launch_tx, abort, halt, req_pend, idle;
   logic start_det, stop_det, scl_rise, scl_fall, gc_match, gc_ev;
   logic wr_trn, wr_con, wr_stat, rd_rcv;

   // Output enable for bit idx of a byte cell; high pulls the data line low
   function automatic logic bit_oe(input i2cm_kind_e kind, input logic [7:0] data, input logic [3:0] idx,
                                   input logic ackv);
      logic oe;
      oe = 1'b0;
      if (kind == K_ACK) begin
         oe = ~ackv;
      end else if (kind == K_TX && idx < `I2CM_ACK_IDX) begin
         oe = ~data[3'(4'h7 - idx)];
      end
      return oe;
   endfunction

   i2cm_brg u_brg (
      .clk(MCLK),
      .rst_n(RESETN),
      .brg(brg)
   );

   assign wr_trn = WR && ADDR == `I2CM_TRN_OFS;
   assign wr_con = WR && ADDR == `I2CM_CON_OFS;
   assign wr_stat = WR && ADDR == `I2CM_STAT_OFS;
   assign rd_rcv = RD && ADDR == `I2CM_RCV_OFS;
   assign idle = state_ff == ST_IDLE;
   assign req_pend = |(con_ff & `I2CM_REQ_MASK);
   assign halt = CPU_IDLE && con_ff[`I2CM_CON_SIDL];
   assign abort = SLEEP && !idle;
   assign launch_tx = wr_trn && idle && !req_pend && !halt;

   // Pins come from another domain; only the second and third stages are read by logic
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_s1 <= SCL_IN;
         scl_s2 <= scl_s1;
         scl_d <= scl_s2;
         sda_s1 <= SDA_IN;
         sda_s2 <= sda_s1;
         sda_d <= sda_s2;
      end
   end

   assign start_det = scl_s2 && scl_d && sda_d && !sda_s2;
   assign stop_det = scl_s2 && scl_d && !sda_d && sda_s2;
   assign scl_rise = scl_s2 && !scl_d;
   assign scl_fall = !scl_s2 && scl_d;

   // Sequencer
   always_comb begin
      nxt_state = state_ff;
      nxt_kind = kind_ff;
      nxt_step = step_ff;
      nxt_bitn = bitn_ff;
      nxt_scl_oe = scl_oe_ff;
      nxt_sda_oe = sda_oe_ff;
      nxt_rx_sh = rx_sh_ff;
      nxt_ack_received = ack_received_ff;
      brg.load = 1'b0;
      brg.run = !halt;
      brg.reload = brg_ff;
      coll = 1'b0;
      cond_done = 1'b0;
      tx_done = 1'b0;
      rx_done = 1'b0;
      if (abort) begin
         nxt_state = ST_IDLE;
         nxt_scl_oe = 1'b0;
         nxt_sda_oe = 1'b0;
      end else if (!halt) begin
         case (state_ff)
            ST_IDLE: begin
               nxt_step = 2'd0;
               if (con_ff[`I2CM_CON_SEN]) begin
                  nxt_state = ST_START;
                  nxt_scl_oe = 1'b0;
                  nxt_sda_oe = 1'b0;
                  brg.load = 1'b1;
               end else if (con_ff[`I2CM_CON_RESTART_REQ]) begin
                  nxt_state = ST_RSTART;
                  nxt_sda_oe = 1'b0;
                  brg.load = 1'b1;
               end else if (con_ff[`I2CM_CON_PEN]) begin
                  nxt_state = ST_STOP;
                  nxt_sda_oe = 1'b1;
                  brg.load = 1'b1;
               end else if (con_ff[`I2CM_CON_ACK_SEQUENCE_REQ] || con_ff[`I2CM_CON_RECEIVE_ENABLE_REQ] || launch_tx) begin
                  nxt_state = ST_BIT;
                  nxt_bitn = 4'h0;
                  nxt_kind = con_ff[`I2CM_CON_ACK_SEQUENCE_REQ] ? K_ACK : (con_ff[`I2CM_CON_RECEIVE_ENABLE_REQ] ? K_RX : K_TX);
                  nxt_sda_oe = bit_oe(nxt_kind, WDATA[7:0], 4'h0, con_ff[`I2CM_CON_ACK_VALUE]);
                  brg.load = 1'b1;
               end
            end
            ST_START: begin
               if (step_ff == 2'd0 && brg.zero) begin
                  if (!sda_s2 || !scl_s2) begin
                     coll = 1'b1;
                  end else begin
                     nxt_sda_oe = 1'b1;
                     brg.load = 1'b1;
                     nxt_step = 2'd1;
                  end
               end else if (step_ff == 2'd1 && brg.zero) begin
                  nxt_scl_oe = 1'b1;
                  cond_done = 1'b1;
                  nxt_state = ST_IDLE;
               end
            end
            ST_RSTART: begin
               if (step_ff == 2'd0 && brg.zero) begin
                  nxt_scl_oe = 1'b0;
                  nxt_step = 2'd1;
               end else if (step_ff == 2'd1 && scl_s2) begin
                  brg.load = 1'b1;
                  nxt_step = 2'd2;
               end else if (step_ff == 2'd2 && brg.zero) begin
                  if (!sda_s2) begin
                     coll = 1'b1;
                  end else begin
                     nxt_sda_oe = 1'b1;
                     brg.load = 1'b1;
                     nxt_step = 2'd3;
                  end
               end else if (step_ff == 2'd3 && brg.zero) begin
                  nxt_scl_oe = 1'b1;
                  cond_done = 1'b1;
                  nxt_state = ST_IDLE;
               end
            end
            ST_STOP: begin
               if (step_ff == 2'd0 && brg.zero) begin
                  nxt_scl_oe = 1'b0;
                  nxt_step = 2'd1;
               end else if (step_ff == 2'd1 && scl_s2) begin
                  brg.load = 1'b1;
                  nxt_step = 2'd2;
               end else if (step_ff == 2'd2 && brg.zero) begin
                  nxt_sda_oe = 1'b0;
                  brg.load = 1'b1;
                  nxt_step = 2'd3;
               end else if (step_ff == 2'd3 && brg.zero) begin
                  if (!sda_s2) begin
                     coll = 1'b1;
                  end else begin
                     cond_done = 1'b1;
                     nxt_state = ST_IDLE;
                  end
               end
            end
            ST_BIT: begin
               if (step_ff == 2'd0 && brg.zero) begin
                  nxt_scl_oe = 1'b0;
                  nxt_step = 2'd1;
               end else if (step_ff == 2'd1 && scl_s2) begin
                  // Counter held at zero while another device stretches the clock
                  brg.load = 1'b1;
                  nxt_step = 2'd2;
                  if (kind_ff == K_RX) begin
                     nxt_rx_sh = {rx_sh_ff[6:0], sda_s2};
                  end
               end else if (step_ff == 2'd2) begin
                  if (!sda_oe_ff && !sda_s2 && (kind_ff == K_ACK || (kind_ff == K_TX && bitn_ff != `I2CM_ACK_IDX))) begin
                     coll = 1'b1;
                  end else if (brg.zero) begin
                     if (kind_ff == K_TX && bitn_ff == `I2CM_ACK_IDX) begin
                        nxt_ack_received = sda_s2;
                     end
                     nxt_scl_oe = 1'b1;
                     nxt_step = 2'd3;
                  end
               end else if (step_ff == 2'd3) begin
                  if (kind_ff == K_ACK || (kind_ff == K_RX && bitn_ff == `I2CM_RX_LAST) || bitn_ff == `I2CM_ACK_IDX) begin
                     nxt_sda_oe = 1'b0;
                     nxt_state = ST_IDLE;
                     cond_done = kind_ff == K_ACK;
                     rx_done = kind_ff == K_RX;
                     tx_done = kind_ff == K_TX;
                  end else begin
                     nxt_bitn = bitn_ff + 4'h1;
                     nxt_sda_oe = bit_oe(kind_ff, trn_ff, bitn_ff + 4'h1, 1'b1);
                     brg.load = 1'b1;
                     nxt_step = 2'd0;
                  end
               end
            end
            default: begin
               nxt_state = ST_IDLE;
            end
         endcase
         if (coll) begin
            nxt_state = ST_IDLE;
            nxt_scl_oe = 1'b0;
            nxt_sda_oe = 1'b0;
         end
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         state_ff <= ST_IDLE;
         kind_ff <= K_TX;
         step_ff <= 2'd0;
         bitn_ff <= 4'h0;
         scl_oe_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
         rx_sh_ff <= 8'h00;
         ack_received_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         kind_ff <= nxt_kind;
         step_ff <= nxt_step;
         bitn_ff <= nxt_bitn;
         scl_oe_ff <= nxt_scl_oe;
         sda_oe_ff <= nxt_sda_oe;
         rx_sh_ff <= nxt_rx_sh;
         ack_received_ff <= nxt_ack_received;
      end
   end

   // Request bits; a software set in the same cycle wins over the hardware clear, except a receive enable set while busy, which is dropped
   always_comb begin
      req_clr = 16'h0000;
      if (coll || abort) begin
         req_clr = `I2CM_REQ_MASK;
      end else if (cond_done) begin
         req_clr[`I2CM_CON_SEN] = state_ff == ST_START;
         req_clr[`I2CM_CON_RESTART_REQ] = state_ff == ST_RSTART;
         req_clr[`I2CM_CON_PEN] = state_ff == ST_STOP;
         req_clr[`I2CM_CON_ACK_SEQUENCE_REQ] = state_ff == ST_BIT;
      end else if (rx_done) begin
         req_clr[`I2CM_CON_RECEIVE_ENABLE_REQ] = 1'b1;
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         con_ff <= `I2CM_CON_RST;
      end else if (wr_con) begin
         con_ff <= WDATA;
         if (WDATA[`I2CM_CON_RECEIVE_ENABLE_REQ] && !con_ff[`I2CM_CON_RECEIVE_ENABLE_REQ] && (!idle || req_pend)) begin
            con_ff[`I2CM_CON_RECEIVE_ENABLE_REQ] <= 1'b0;
         end
      end else begin
         con_ff <= con_ff & ~req_clr;
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         trn_ff <= `I2CM_TRN_RST;
         brg_ff <= `I2CM_BRG_RST;
         add_ff <= `I2CM_ADD_RST;
      end else if (WR) begin
         if (launch_tx) begin
            trn_ff <= WDATA[7:0];
         end
         if (ADDR == `I2CM_BRG_OFS) begin
            brg_ff <= WDATA;
         end
         if (ADDR == `I2CM_ADD_OFS) begin
            add_ff <= WDATA;
         end
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         tbf_ff <= 1'b0;
         tx_in_progress_ff <= 1'b0;
      end else if (launch_tx) begin
         tbf_ff <= 1'b1;
         tx_in_progress_ff <= 1'b1;
      end else if (tx_done || coll || abort) begin
         tbf_ff <= 1'b0;
         tx_in_progress_ff <= 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         bcl_ff <= 1'b0;
      end else if (coll) begin
         bcl_ff <= 1'b1;
      end else if (wr_stat && !WDATA[`I2CM_ST_BCL]) begin
         bcl_ff <= 1'b0;
      end
   end

   // Bus free tracking for software arbitration
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         s_ff <= 1'b0;
         p_ff <= 1'b0;
      end else if (start_det) begin
         s_ff <= 1'b1;
         p_ff <= 1'b0;
      end else if (stop_det) begin
         s_ff <= 1'b0;
         p_ff <= 1'b1;
      end
   end

   // General call snoop on the first byte after any Start
   assign gc_match = scl_rise && mon_arm_ff && mon_cnt_ff == `I2CM_RX_LAST && {mon_sh_ff[6:0], sda_s2} == 8'h00
                     && con_ff[`I2CM_CON_GENERAL_CALL_ENABLE];
   // Nine rises are counted so the event lands on the ninth fall, after the ack cell
   assign gc_ev = scl_fall && gc_pend_ff && mon_cnt_ff > `I2CM_ACK_IDX;

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         mon_arm_ff <= 1'b0;
         mon_cnt_ff <= 4'h0;
         mon_sh_ff <= 8'h00;
         gc_pend_ff <= 1'b0;
      end else if (start_det) begin
         mon_arm_ff <= 1'b1;
         mon_cnt_ff <= 4'h0;
         gc_pend_ff <= 1'b0;
      end else if (scl_rise && mon_arm_ff && mon_cnt_ff <= `I2CM_ACK_IDX) begin
         mon_sh_ff <= {mon_sh_ff[6:0], sda_s2};
         mon_cnt_ff <= mon_cnt_ff + 4'h1;
         gc_pend_ff <= gc_pend_ff || gc_match;
      end else if (scl_fall && mon_cnt_ff > `I2CM_ACK_IDX) begin
         mon_arm_ff <= 1'b0;
         mon_cnt_ff <= 4'h0;
         gc_pend_ff <= 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         rcv_ff <= `I2CM_RCV_RST;
         rbf_ff <= 1'b0;
         gcstat_ff <= 1'b0;
      end else begin
         if (rx_done) begin
            rcv_ff <= rx_sh_ff;
         end else if (gc_match) begin
            rcv_ff <= 8'h00;
         end
         if (rx_done || gc_match) begin
            rbf_ff <= 1'b1;
         end else if (rd_rcv) begin
            rbf_ff <= 1'b0;
         end
         if (gc_match) begin
            gcstat_ff <= 1'b1;
         end else if (stop_det) begin
            gcstat_ff <= 1'b0;
         end
      end
   end

   // Master event pulse and the watch for Stop after a lost arbitration
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         event_ff <= 1'b0;
         coll_wait_ff <= 1'b0;
      end else begin
         event_ff <= coll || cond_done || tx_done || rx_done || gc_ev || (coll_wait_ff && stop_det);
         if (coll) begin
            coll_wait_ff <= 1'b1;
         end else if (stop_det) begin
            coll_wait_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         rdata_ff <= 16'h0000;
         low_ff <= 1'b0;
      end else if (RD) begin
         case (ADDR)
            `I2CM_RCV_OFS: rdata_ff <= {8'h00, rcv_ff};
            `I2CM_TRN_OFS: rdata_ff <= {8'h00, trn_ff};
            `I2CM_BRG_OFS: rdata_ff <= brg_ff;
            `I2CM_CON_OFS: rdata_ff <= con_ff;
            `I2CM_STAT_OFS: rdata_ff <= {ack_received_ff, tx_in_progress_ff, 3'b000, bcl_ff, gcstat_ff, 4'h0, p_ff, s_ff, 1'b0, rbf_ff,
                                         tbf_ff};
            `I2CM_ADD_OFS: rdata_ff <= add_ff;
            default: rdata_ff <= 16'h0000;
         endcase
      end else begin
         rdata_ff <= 16'h0000;
      end
   end

   assign RDATA = rdata_ff;
   assign SCL_OUT = low_ff;
   assign SDA_OUT = low_ff;
   assign SCL_OE = scl_oe_ff;
   assign SDA_OE = sda_oe_ff;
   assign MASTER_EVENT = event_ff;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESETN);

   tx_launch_a: assert property (launch_tx |=> tbf_ff && tx_in_progress_ff && state_ff == ST_BIT && bitn_ff == 4'h0)
      else $error("transmit write did not launch a byte");
   receive_enable_req_busy_a: assert property (wr_con && WDATA[`I2CM_CON_RECEIVE_ENABLE_REQ] && !con_ff[`I2CM_CON_RECEIVE_ENABLE_REQ] && !idle
                                 |=> !con_ff[`I2CM_CON_RECEIVE_ENABLE_REQ])
      else $error("receive enable accepted while busy");
   coll_idle_a: assert property (coll |=> idle && MASTER_EVENT && bcl_ff)
      else $error("collision did not return master to idle");
   coll_release_a: assert property (coll |=> !SCL_OE && !SDA_OE && !tbf_ff && !(|(con_ff & `I2CM_REQ_MASK)))
      else $error("collision left lines or flags held");
   brg_halt_a: assert property (brg.zero && !brg.load |=> brg.zero)
      else $error("baud counter moved without a reload");
   scl_wait_a: assert property (state_ff == ST_BIT && step_ff == 2'd1 && !scl_s2 |-> !brg.load)
      else $error("baud counter reloaded before clock seen high");
   sda_order_a: assert property (state_ff == ST_BIT && $changed(SDA_OE) && !$past(coll) && !$past(abort)
                                 |-> SCL_OE && $past(SCL_OE))
      else $error("data changed while clock released");
   stop_watch_a: assert property (coll_wait_ff && stop_det |=> MASTER_EVENT ##1 !coll_wait_ff)
      else $error("stop after collision raised no event");
   sleep_abort_a: assert property (abort |=> idle && !tx_in_progress_ff && !SCL_OE && !SDA_OE)
      else $error("sleep did not abort the transfer");
endmodule // i2cm_master

/* hw/i2cm_consts.svh */
// Register offsets, field positions and reset values of the two-wire master
`ifndef I2CM_CONSTS_SVH
`define I2CM_CONSTS_SVH
`define I2CM_RCV_OFS 16'h0200
`define I2CM_TRN_OFS 16'h0202
`define I2CM_BRG_OFS 16'h0204
`define I2CM_CON_OFS 16'h0206
`define I2CM_STAT_OFS 16'h0208
`define I2CM_ADD_OFS 16'h020A
`define I2CM_RCV_RST 8'h00
`define I2CM_TRN_RST 8'hFF
`define I2CM_BRG_RST 16'h0000
`define I2CM_CON_RST 16'h1000
`define I2CM_ADD_RST 16'h0000
`define I2CM_CON_SEN 0
`define I2CM_CON_RESTART_REQ 1
`define I2CM_CON_PEN 2
`define I2CM_CON_ACK_SEQUENCE_REQ 4
`define I2CM_CON_ACK_VALUE 5
`define I2CM_CON_RECEIVE_ENABLE_REQ 11
`define I2CM_CON_SIDL 13
`define I2CM_CON_GENERAL_CALL_ENABLE 15
`define I2CM_REQ_MASK 16'h0837
`define I2CM_ST_ACK_RECEIVED 15
`define I2CM_ST_TX_IN_PROGRESS 14
`define I2CM_ST_BCL 10
`define I2CM_ST_GCSTAT 9
`define I2CM_ST_P 4
`define I2CM_ST_S 3
`define I2CM_ST_RBF 1
`define I2CM_ST_TBF 0
`define I2CM_ACK_IDX 4'h8
`define I2CM_RX_LAST 4'h7
`endif

/* hw/i2cm_pkg.sv */
// Types shared by the two-wire master modules
package i2cm_pkg;
   typedef enum logic [4:0] {ST_IDLE = 5'h01, ST_START = 5'h02, ST_RSTART = 5'h04, ST_STOP = 5'h08,
                             ST_BIT = 5'h10} i2cm_state_e;
   typedef enum logic [2:0] {K_TX = 3'h1, K_RX = 3'h2, K_ACK = 3'h4} i2cm_kind_e;
   typedef logic [15:0] i2cm_word_t;
endpackage

/* hw/i2cm_brg_if.sv */
// Link between the sequencer and the baud counter
`timescale 1ns/10ps
interface i2cm_brg_if;
   logic load;
   logic run;
   logic [15:0] reload;
   logic zero;
   modport ctl (output load, output run, output reload, input zero);
   modport gen (input load, input run, input reload, output zero);
endinterface

/* hw/i2cm_brg.sv */
// Reload-and-count-down baud counter
`timescale 1ns/10ps
module i2cm_brg (
   input wire logic clk,
   input wire logic rst_n,
   i2cm_brg_if.gen brg
);
   import i2cm_pkg::*;
   i2cm_word_t count_ff;

   // Stops at zero until reloaded; a reload of 0 or 1 gives no usable half period
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_ff <= 16'h0000;
      end else if (brg.load) begin
         count_ff <= brg.reload;
      end else if (brg.run && count_ff != 16'h0000) begin
         count_ff <= count_ff - 16'h0001;
      end
   end

   assign brg.zero = (count_ff == 16'h0000);
endmodule // i2cm_brg

/* verification/i2cm_slave.sv */
// Behavioural slave device on the two-wire bus
`timescale 1ns/10ps
module i2cm_slave (
   input wire logic scl,
   input wire logic sda,
   input wire logic [7:0] tx_byte,
   input wire logic jam,
   output logic sda_oe,
   output logic [7:0] got
);
   logic [3:0] cnt = 4'h0;
   logic [7:0] sh = 8'h00;
   logic rd_mode = 1'b0;
   logic first = 1'b0;
   logic drv = 1'b0;
   assign sda_oe = drv | jam; // Jam only when the bench wants a collision
   always @(negedge sda) if (scl) begin
      cnt = 4'h0;
      first = 1'b1;
      rd_mode = 1'b0;
   end
   always @(posedge scl) begin
      sh = {sh[6:0], sda};
      if (cnt == 4'h7 && !rd_mode) got = sh;
      cnt = cnt + 4'h1;
      if (cnt == 4'h9) begin
         cnt = 4'h0;
         rd_mode = (rd_mode & ~sda) | (first & got[0]);
         first = 1'b0;
      end
   end
   // Changes only while the clock is low, so the master never sees a false start
   always @(negedge scl) drv = (cnt == 4'h8 && !rd_mode) ||
      (rd_mode && cnt < 4'h8 && !tx_byte[3'h7 - cnt[2:0]]);
endmodule // i2cm_slave

/* verification/tb.sv */
// Self-checking bench for the two-wire master
`timescale 1ns/10ps
module tb;
   import i2cm_pkg::*;
   logic mclk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, jam = 1'b0, scl_oe, sda_oe, s_oe, ev;
   logic sleep = 1'b0, cpu_idle = 1'b0;
   i2cm_word_t addr = 16'h0000, wdata = 16'h0000, rdata;
   i2cm_word_t ofs[7] = '{16'h0200, 16'h0202, 16'h0204, 16'h0206, 16'h0208, 16'h020A, 16'h020C};
   i2cm_word_t rst[7] = '{16'h0000, 16'h00FF, 16'h0000, 16'h1000, 16'h0000, 16'h0000, 16'h0000};
   logic [7:0] rx_b = 8'h00, got;
   int num_errors = 0, checks_done = 0;
   wire scl = ~scl_oe;
   wire sda = ~(sda_oe | s_oe);
   always #50 mclk = ~mclk;
   i2cm_master dut (.MCLK(mclk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .SCL_IN(scl), .SCL_OUT(), .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe), .SLEEP(sleep),
      .CPU_IDLE(cpu_idle), .MASTER_EVENT(ev));
   i2cm_slave peer (.scl(scl), .sda(sda), .tx_byte(rx_b), .jam(jam), .sda_oe(s_oe), .got(got));
   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(string n, i2cm_word_t e, i2cm_word_t s);
      checks_done++;
      if (s !== e) begin
         $display("mismatch %s expected %h seen %h", n, e, s);
         num_errors++;
      end
   endtask
   task automatic wreg(i2cm_word_t a, i2cm_word_t d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rreg(i2cm_word_t a, i2cm_word_t m, i2cm_word_t e, string n);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      chk(n, e, rdata & m);
   endtask
   // Bounded so a silent master cannot hang the run
   task automatic wait_ev();
      int i;
      for (i = 0; i < 4000 && ev !== 1'b1; i++) @(negedge mclk);
      if (ev !== 1'b1) begin
         num_errors++;
         final_report();
      end
   endtask
   task automatic send(logic [7:0] d);
      wreg(16'h0202, {8'h00, d});
      rreg(16'h0208, 16'h4001, 16'h4001, "tx flags");
      wreg(16'h0206, 16'h1800);
      rreg(16'h0206, 16'h0800, 16'h0000, "rx enable busy");
      wait_ev();
      chk("byte on wire", {8'h00, d}, {8'h00, got});
      rreg(16'h0208, 16'hC001, 16'h0000, "ack and idle");
   endtask
   initial begin
      void'($urandom(92));
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      cpu_idle <= 1'b1;
      foreach (ofs[k]) rreg(ofs[k], 16'hFFFF, rst[k], "reset value");
      wreg(16'h0204, 16'h0004);
      rreg(16'h0204, 16'hFFFF, 16'h0004, "divider");
      wreg(16'h0206, 16'h1001);
      wait_ev();
      chk("scl held", 16'h0001, {15'h0000, scl_oe});
      rreg(16'h0206, 16'h0001, 16'h0000, "start req");
      send({7'($urandom), 1'b0});
      send(8'($urandom));
      wreg(16'h0206, 16'h1002);
      wait_ev();
      rreg(16'h0206, 16'h0002, 16'h0000, "restart req");
      rx_b = 8'($urandom);
      send({7'($urandom), 1'b1});
      // Ack keeps the slave sending the same byte; the final nack lets it go
      for (int k = 0; k < 2; k++) begin
         wreg(16'h0206, 16'h1800);
         wait_ev();
         rreg(16'h0208, 16'h0002, 16'h0002, "rx full");
         rreg(16'h0200, 16'hFFFF, {8'h00, rx_b}, "rx byte");
         wreg(16'h0206, k ? 16'h1030 : 16'h1010);
         wait_ev();
         rreg(16'h0206, 16'h0010, 16'h0000, "ack req");
      end
      wreg(16'h0206, 16'h1004);
      wait_ev();
      chk("lines free", 16'h0000, {14'h0000, scl_oe, sda_oe});
      rreg(16'h0208, 16'h0012, 16'h0010, "stop seen");
      wreg(16'h0206, 16'h9001);
      wait_ev();
      wreg(16'h0202, 16'h0000);
      wait_ev();
      @(negedge mclk);
      wait_ev();
      rreg(16'h0208, 16'h0203, 16'h0202, "general call");
      rreg(16'h0200, 16'hFFFF, 16'h0000, "general call byte");
      jam <= 1'b1;
      wreg(16'h0202, 16'h00FF);
      wait_ev();
      rreg(16'h0208, 16'h4401, 16'h0400, "collision");
      chk("lines free", 16'h0000, {14'h0000, scl_oe, sda_oe});
      jam <= 1'b0;
      wait_ev();
      wreg(16'h0208, 16'h0000);
      wreg(16'h0206, 16'h1001);
      wait_ev();
      send({1'b1, 6'($urandom), 1'b0});
      wreg(16'h0206, 16'h1004);
      wait_ev();
      rreg(16'h0208, 16'h0010, 16'h0010, "final stop");
      wreg(16'h0206, 16'h1001);
      wait_ev();
      wreg(16'h0202, {8'h00, 8'($urandom)});
      repeat (20) @(posedge mclk);
      sleep <= 1'b1;
      @(posedge mclk);
      sleep <= 1'b0;
      rreg(16'h0208, 16'h4001, 16'h0000, "sleep abort");
      chk("lines free", 16'h0000, {14'h0000, scl_oe, sda_oe});
      wreg(16'h0206, 16'h3000);
      wreg(16'h0202, 16'h0055);
      rreg(16'h0208, 16'h4001, 16'h0000, "halted in idle");
      final_report();
   end
endmodule // tb
